// ===== core/eth_port_defines.svh
/*
 * Address map, field positions and reset values of the Ethernet FIFO data
 * port and transmit status block.
 * Assumes an AHB-Lite slave that decodes full 32-bit byte addresses.
 */
`ifndef ETH_PORT_DEFINES_SVH
`define ETH_PORT_DEFINES_SVH

`define ADDR_CONTROL        32'hFF80_0000
`define ADDR_GEN_STATUS     32'hFF80_0004
`define ADDR_FIFO_PRIMARY   32'hFF80_0008
`define ADDR_FIFO_LAST      32'hFF80_000C
`define ADDR_TX_STATUS      32'hFF80_0010
`define ADDR_RX_STATUS      32'hFF80_0014
`define ADDR_RX_LEVEL       32'hFF80_0018

`define CTRL_DMA_MODE       0
`define GS_RX_READY         25
`define GS_TX_SPACE         19
`define GS_TX_HALF          18
`define GS_TX_DONE          17
`define GS_TX_EMPTY         16

`define TS_OK               15
`define TS_BCAST            14
`define TS_MCAST            13
`define TS_LATE_COLL        12
`define TS_DEFERRAL         11
`define TS_COLL_LIMIT       10
`define TS_LOW_W            16

`define RESET_WORD          32'h0000_0000
`define HTRANS_NONSEQ       2'h2
`define HRESP_OKAY          1'h0

`endif

// ===== core/eth_port_pkg.sv
/*
 * Types carried between the FIFO port block and the MAC engine.
 * Assumes the MAC engine runs on the same clock as the bus.
 */
package eth_port_pkg;

    typedef struct packed {
        logic        ok;
        logic        bcast;
        logic        mcast;
        logic        late_coll;
        logic        deferral;
        logic        coll_limit;
    } tx_result_s;

    typedef struct packed {
        logic [31:0] data;
        logic [2:0]  bytes;
        logic        last;
    } rx_word_s;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } tx_word_s;

endpackage : eth_port_pkg

// ===== core/eth_fifo_port.sv
/*
 * FIFO data port and transmit status register of an Ethernet MAC, with the
 * general status flags they drive, behind an AHB-Lite slave.
 * Assumes a MAC engine on hclk that pushes received words, pulls transmit
 * words and reports each transmit outcome with a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "eth_port_defines.svh"

module eth_fifo_port
    import eth_port_pkg::*;
#(
    parameter int RX_DEPTH = 16,
    parameter int TX_DEPTH = 16
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Receive side of the MAC engine.
    input  wire logic        rx_wr_valid,
    input  wire rx_word_s    rx_wr_word,
    output logic             rx_wr_ready,
    input  wire logic [31:0] rx_frame_status,
    // Transmit side of the MAC engine.
    output logic             tx_rd_valid,
    output tx_word_s         tx_rd_word,
    input  wire logic        tx_rd_ready,
    input  wire logic        tx_result_valid,
    input  wire tx_result_s  tx_result,
    // DMA descriptor and status hand-off.
    output logic             desc_status_we,
    output logic [15:0]      descriptor_status_field,
    output logic             rx_status_dma_valid,
    output logic [31:0]      rx_status_dma
);

    localparam int RX_PW = $clog2(RX_DEPTH);
    localparam int TX_PW = $clog2(TX_DEPTH);
    localparam int RX_LW = RX_PW + 3;

    function automatic logic [RX_PW-1:0] rx_step(input logic [RX_PW-1:0] p);
        rx_step = (p == RX_PW'(RX_DEPTH - 1)) ? '0 : RX_PW'(p + 1'b1);
    endfunction : rx_step

    function automatic logic [TX_PW-1:0] tx_step(input logic [TX_PW-1:0] p);
        tx_step = (p == TX_PW'(TX_DEPTH - 1)) ? '0 : TX_PW'(p + 1'b1);
    endfunction : tx_step

    // Bus phase state.
    logic              pend;
    logic [31:0]       a_addr;
    logic              a_write;
    logic              wr_acc;
    logic              rd_acc;

    // Control and flags.
    logic              dma_mode;
    logic              rx_frame_ready_flag;
    logic              rx_open;
    logic              tx_done_flag;
    logic              tx_space_flag;
    logic              tx_half_free_flag;
    logic [31:0]       tx_status;
    logic [31:0]       rx_status;
    logic              rx_clr;
    logic              tx_clr;

    // Receive FIFO.
    logic [31:0]       rx_mem_data [RX_DEPTH];
    logic [2:0]        rx_mem_bytes [RX_DEPTH];
    logic              rx_mem_last [RX_DEPTH];
    logic [RX_PW-1:0]  rx_wp;
    logic [RX_PW-1:0]  rx_rp;
    logic [RX_PW:0]    rx_cnt;
    logic [RX_LW-1:0]  rx_level;
    logic              rx_push;
    logic              rx_pop;

    // Transmit FIFO.
    logic [31:0]       tx_mem_data [TX_DEPTH];
    logic              tx_mem_last [TX_DEPTH];
    logic [TX_PW-1:0]  tx_wp;
    logic [TX_PW-1:0]  tx_rp;
    logic [TX_PW:0]    tx_cnt;
    logic              tx_push;
    logic              tx_pop;
    logic              tx_flush;
    logic [31:0]       next_tx_status;
    logic [31:0]       read_word;

    // Address phase is taken when selected and ready; one wait state follows.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend    <= 1'b0;
            a_addr  <= `RESET_WORD;
            a_write <= 1'b0;
        end else if (pend) begin
            pend <= 1'b0;
        end else if (hsel && hready && htrans == `HTRANS_NONSEQ) begin
            pend    <= 1'b1;
            a_addr  <= haddr;
            a_write <= hwrite;
        end
    end

    assign wr_acc    = pend && a_write;
    assign rd_acc    = pend && !a_write;
    assign hreadyout = !pend;
    assign hresp     = `HRESP_OKAY;

    // Control register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_mode <= 1'b0;
        end else if (wr_acc && a_addr == `ADDR_CONTROL) begin
            dma_mode <= hwdata[`CTRL_DMA_MODE];
        end
    end

    // Write-one-to-clear strobes; DMA mode clears the receive flag itself.
    assign rx_clr = rx_frame_ready_flag &&
                    (dma_mode || (wr_acc && a_addr == `ADDR_GEN_STATUS &&
                                  hwdata[`GS_RX_READY]));
    assign tx_clr = wr_acc && a_addr == `ADDR_GEN_STATUS && hwdata[`GS_TX_DONE];

    // Receive FIFO fill from the MAC engine.
    assign rx_wr_ready = rx_cnt != (RX_PW+1)'(RX_DEPTH);
    assign rx_push     = rx_wr_valid && rx_wr_ready;
    assign rx_pop      = rd_acc && a_addr == `ADDR_FIFO_PRIMARY && rx_open &&
                         rx_cnt != '0;

    always_ff @(posedge hclk) begin
        if (rx_push) begin
            rx_mem_data[rx_wp]  <= rx_wr_word.data;
            rx_mem_bytes[rx_wp] <= rx_wr_word.bytes;
            rx_mem_last[rx_wp]  <= rx_wr_word.last;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_wp    <= '0;
            rx_rp    <= '0;
            rx_cnt   <= '0;
            rx_level <= '0;
        end else begin
            if (rx_push) begin
                rx_wp <= rx_step(rx_wp);
            end
            if (rx_pop) begin
                rx_rp <= rx_step(rx_rp);
            end
            rx_cnt   <= rx_cnt + (RX_PW+1)'(rx_push) - (RX_PW+1)'(rx_pop);
            rx_level <= rx_level
                      + (rx_push ? RX_LW'(rx_wr_word.bytes) : '0)
                      - (rx_pop ? RX_LW'(rx_mem_bytes[rx_rp]) : '0);
        end
    end

    // Receive frame ready flag: a new frame end wins over a clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_frame_ready_flag <= 1'b0;
            rx_status           <= `RESET_WORD;
        end else begin
            if (rx_push && rx_wr_word.last) begin
                rx_frame_ready_flag <= 1'b1;
                rx_status           <= rx_frame_status;
            end else if (rx_clr) begin
                rx_frame_ready_flag <= 1'b0;
            end
        end
    end

    // The FIFO opens once the flag is cleared and closes after a last word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_open <= 1'b0;
        end else if (rx_clr) begin
            rx_open <= 1'b1;
        end else if (rx_pop && rx_mem_last[rx_rp]) begin
            rx_open <= 1'b0;
        end
    end

    // Receive status handed to DMA when the flag is cleared automatically.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_status_dma_valid <= 1'b0;
            rx_status_dma       <= `RESET_WORD;
        end else begin
            rx_status_dma_valid <= rx_clr && dma_mode;
            if (rx_clr && dma_mode) begin
                rx_status_dma <= rx_status;
            end
        end
    end

    // Transmit FIFO fill from the bus; the last-word address ends a frame.
    assign tx_push  = wr_acc && tx_space_flag &&
                      (a_addr == `ADDR_FIFO_PRIMARY ||
                       a_addr == `ADDR_FIFO_LAST);
    assign tx_flush = tx_result_valid && !tx_result.ok;
    assign tx_rd_valid     = tx_cnt != '0;
    assign tx_rd_word.data = tx_mem_data[tx_rp];
    assign tx_rd_word.last = tx_mem_last[tx_rp];
    assign tx_pop          = tx_rd_valid && tx_rd_ready && !tx_flush;

    always_ff @(posedge hclk) begin
        if (tx_push) begin
            tx_mem_data[tx_wp] <= hwdata;
            tx_mem_last[tx_wp] <= a_addr == `ADDR_FIFO_LAST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end else if (tx_flush) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_step(tx_wp);
            end
            if (tx_pop) begin
                tx_rp <= tx_step(tx_rp);
            end
            tx_cnt <= tx_cnt + (TX_PW+1)'(tx_push) - (TX_PW+1)'(tx_pop);
        end
    end

    // Space flags stay off while a completed frame awaits acknowledgement.
    assign tx_space_flag     = !tx_done_flag &&
                               tx_cnt != (TX_PW+1)'(TX_DEPTH);
    assign tx_half_free_flag = !tx_done_flag &&
                               (TX_PW+1)'(TX_DEPTH) - tx_cnt >=
                               (TX_PW+1)'(TX_DEPTH / 2);

    // Outcome word for the frame that just finished.
    always_comb begin
        next_tx_status                = `RESET_WORD;
        next_tx_status[`TS_OK]        = tx_result.ok;
        next_tx_status[`TS_BCAST]     = tx_result.bcast;
        next_tx_status[`TS_MCAST]     = tx_result.mcast;
        next_tx_status[`TS_LATE_COLL] = tx_result.late_coll;
        next_tx_status[`TS_DEFERRAL]  = tx_result.deferral;
        next_tx_status[`TS_COLL_LIMIT] = tx_result.coll_limit;
    end

    // Status changes only on a frame outcome, never on a read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_status <= `RESET_WORD;
        end else if (tx_result_valid) begin
            tx_status <= next_tx_status;
        end
    end

    // Done flag: a new outcome wins over a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_done_flag <= 1'b0;
        end else if (tx_result_valid) begin
            tx_done_flag <= 1'b1;
        end else if (tx_clr) begin
            tx_done_flag <= 1'b0;
        end
    end

    // Descriptor copy of the low half in DMA mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            desc_status_we          <= 1'b0;
            descriptor_status_field <= '0;
        end else begin
            desc_status_we <= tx_result_valid && dma_mode;
            if (tx_result_valid && dma_mode) begin
                descriptor_status_field <= next_tx_status[`TS_LOW_W-1:0];
            end
        end
    end

    // Read multiplexer; unmapped and write-only addresses read zero.
    always_comb begin
        read_word = `RESET_WORD;
        if (a_addr == `ADDR_CONTROL) begin
            read_word[`CTRL_DMA_MODE] = dma_mode;
        end else if (a_addr == `ADDR_GEN_STATUS) begin
            read_word[`GS_RX_READY] = rx_frame_ready_flag;
            read_word[`GS_TX_SPACE] = tx_space_flag;
            read_word[`GS_TX_HALF]  = tx_half_free_flag;
            read_word[`GS_TX_DONE]  = tx_done_flag;
            read_word[`GS_TX_EMPTY] = tx_cnt == '0;
        end else if (a_addr == `ADDR_FIFO_PRIMARY) begin
            read_word = rx_pop ? rx_mem_data[rx_rp] : `RESET_WORD;
        end else if (a_addr == `ADDR_TX_STATUS) begin
            read_word = tx_status;
        end else if (a_addr == `ADDR_RX_STATUS) begin
            read_word = rx_status;
        end else if (a_addr == `ADDR_RX_LEVEL) begin
            read_word = 32'(rx_level);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `RESET_WORD;
        end else if (rd_acc) begin
            hrdata <= read_word;
        end
    end

endmodule : eth_fifo_port

// ===== testbench/eth_port_sva.sv
/*
 * Concurrent assertions on the ports of the FIFO port block.
 * Assumes one hclk domain and a bind into every eth_fifo_port instance.
 */
`timescale 1ns/1ps
`include "eth_port_defines.svh"

module eth_port_sva
    import eth_port_pkg::*;
#(
    parameter int RX_DEPTH = 16,
    parameter int TX_DEPTH = 16
) (
    // Clock, reset and bus.
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Engine side.
    input wire logic        rx_wr_valid,
    input wire logic        rx_wr_ready,
    input wire rx_word_s    rx_wr_word,
    input wire logic [31:0] rx_frame_status,
    input wire logic        tx_rd_valid,
    input wire logic        tx_result_valid,
    input wire tx_result_s  tx_result,
    input wire logic        desc_status_we,
    input wire logic [15:0] descriptor_status_field,
    input wire logic        rx_status_dma_valid,
    input wire logic [31:0] rx_status_dma
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [31:0] cap;

    // Holds the receive status offered with the last pushed frame end.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap <= `RESET_WORD;
        end else if (rx_wr_valid && rx_wr_ready && rx_wr_word.last) begin
            cap <= rx_frame_status;
        end
    end

    sequence s_take;
        hsel && hready && hreadyout && htrans == `HTRANS_NONSEQ;
    endsequence
    sequence s_read(logic [31:0] a);
        s_take ##0 !hwrite && haddr == a;
    endsequence
    sequence s_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    a_okay_resp: assert property (hresp == `HRESP_OKAY)
        else $error("bus response not okay");
    a_one_wait: assert property (s_take |=> s_answer)
        else $error("data phase not one wait state");
    a_last_reads_zero: assert property (s_read(`ADDR_FIFO_LAST) |=> ##1 hrdata == 32'h0)
        else $error("last word address read not zero");
    a_status_reserved: assert property (s_read(`ADDR_TX_STATUS) |=> ##1
        hrdata[31:16] == 16'h0 && hrdata[9:0] == 10'h0)
        else $error("reserved status bits not zero");
    a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed without a read");
    a_desc_cause: assert property (desc_status_we |-> $past(tx_result_valid))
        else $error("descriptor write without outcome");
    a_desc_value: assert property (desc_status_we |->
        descriptor_status_field == {$past(tx_result), 10'h000})
        else $error("descriptor field wrong");
    a_abort_flush: assert property (tx_result_valid && !tx_result.ok |=> !tx_rd_valid)
        else $error("abort did not flush transmit fifo");
    a_rx_dma_copy: assert property (rx_status_dma_valid |-> rx_status_dma == cap)
        else $error("automatic receive status copy wrong");
endmodule : eth_port_sva

bind eth_fifo_port eth_port_sva #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) sva_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .rx_wr_valid, .rx_wr_ready, .rx_wr_word, .rx_frame_status, .tx_rd_valid,
    .tx_result_valid, .tx_result, .desc_status_we, .descriptor_status_field,
    .rx_status_dma_valid, .rx_status_dma
);

// ===== testbench/mac_model.sv
/*
 * Behavioural MAC engine on the far side of the FIFO port block.
 * Assumes commands from the testbench on hclk.
 */
`timescale 1ns/1ps

module mac_model
    import eth_port_pkg::*;
#(
    parameter logic [31:0] W0    = 32'h0,
    parameter logic [31:0] W1    = 32'h0,
    parameter logic [31:0] FSTAT = 32'h0
) (
    // Clock, reset and commands.
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       rx_go,
    input  wire logic       tx_stall,
    input  wire logic       res_go,
    input  wire logic [5:0] res_in,
    // Receive stream.
    input  wire logic       rx_wr_ready,
    output logic            rx_wr_valid,
    output rx_word_s        rx_wr_word,
    output logic [31:0]     rx_frame_status,
    // Transmit stream and outcome.
    input  wire logic       tx_rd_valid,
    input  wire tx_word_s   tx_rd_word,
    output logic            tx_rd_ready,
    output logic            tx_result_valid,
    output tx_result_s      tx_result,
    output logic [7:0]      pops,
    output logic            last_seen,
    output logic [31:0]     last_data
);
    logic [1:0] n;

    assign rx_frame_status = FSTAT;

    // Pushes a two-word frame; idle data shows the inverse of the last word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n <= 2'h0;
            rx_wr_valid <= 1'b0;
            rx_wr_word <= '0;
        end else if (rx_go && n == 2'h0) begin
            n <= 2'h1;
            rx_wr_valid <= 1'b1;
            rx_wr_word <= '{W0, 3'h4, 1'b0};
        end else if (rx_wr_valid && rx_wr_ready) begin
            if (n == 2'h1) begin
                n <= 2'h2;
                rx_wr_word <= '{W1, 3'h2, 1'b1};
            end else begin
                n <= 2'h0;
                rx_wr_valid <= 1'b0;
                rx_wr_word.data <= ~rx_wr_word.data;
            end
        end
    end

    // Takes transmit words unless stalled, and reports outcomes as pulses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_rd_ready <= 1'b0;
            pops <= 8'h00;
            last_seen <= 1'b0;
            last_data <= 32'h0;
            tx_result_valid <= 1'b0;
            tx_result <= '0;
        end else begin
            tx_rd_ready <= !tx_stall;
            tx_result_valid <= res_go;
            tx_result <= res_go ? res_in : ~tx_result;
            if (tx_rd_valid && tx_rd_ready) begin
                pops <= pops + 8'h01;
                last_seen <= tx_rd_word.last;
                last_data <= tx_rd_word.data;
            end
        end
    end
endmodule : mac_model

// ===== testbench/tb_eth_fifo_port.sv
/*
 * Directed testbench of the FIFO port block over AHB-Lite.
 * Assumes mac_model as the engine and the bound checker.
 */
`timescale 1ns/1ps
`include "eth_port_defines.svh"

module tb_eth_fifo_port
    import eth_port_pkg::*;
;
    localparam logic [31:0] W0 = 32'hA5A5_0001;
    localparam logic [31:0] W1 = 32'h5A5A_0002;
    localparam logic [31:0] FSTAT = 32'h0000_1234;
    localparam logic [31:0] GS = `ADDR_GEN_STATUS;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic rx_go = 1'b0;
    logic res_go = 1'b0;
    logic tx_stall = 1'b0;
    logic [5:0] res_in = 6'h0;
    logic [15:0] desc_seen = 16'h0;
    logic [31:0] hrdata, rd, rx_frame_status, rx_status_dma;
    logic hreadyout, hresp, rx_wr_valid, rx_wr_ready, tx_rd_valid, tx_rd_ready;
    logic tx_result_valid, desc_status_we, rx_status_dma_valid, last_seen;
    logic [15:0] descriptor_status_field;
    logic [7:0] pops;
    logic [31:0] last_data;
    logic [31:0] dma_stat = 32'h0;
    rx_word_s rx_wr_word;
    tx_word_s tx_rd_word;
    tx_result_s tx_result;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int dma_cnt = 0;
    wire logic hready;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    eth_fifo_port #(.RX_DEPTH(4), .TX_DEPTH(4)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp, .rx_wr_valid, .rx_wr_word, .rx_wr_ready,
        .rx_frame_status, .tx_rd_valid, .tx_rd_word, .tx_rd_ready, .tx_result_valid,
        .tx_result, .desc_status_we, .descriptor_status_field, .rx_status_dma_valid,
        .rx_status_dma
    );

    mac_model #(.W0(W0), .W1(W1), .FSTAT(FSTAT)) partner (
        .hclk, .hresetn, .rx_go, .tx_stall, .res_go, .res_in, .rx_wr_ready, .rx_wr_valid,
        .rx_wr_word, .rx_frame_status, .tx_rd_valid, .tx_rd_word, .tx_rd_ready,
        .tx_result_valid, .tx_result, .pops, .last_seen, .last_data
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Watches engine pulses and cuts a hang short.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (desc_status_we) begin
            desc_seen <= descriptor_status_field;
        end
        if (rx_status_dma_valid) begin
            dma_cnt <= dma_cnt + 1;
            dma_stat <= rx_status_dma;
        end
        if (cyc == 20000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("unmapped", 32'hFF80_0020, 32'h0);
        rd_chk("last word read", `ADDR_FIFO_LAST, 32'h0);
        rd_chk("tx status reset", `ADDR_TX_STATUS, 32'h0);
        xfer(1'b0, GS, 32'h0);
        chk("space flag", 32'h1, {31'h0, rd[19]});
        xfer(1'b1, `ADDR_FIFO_PRIMARY, 32'h1111_0000);
        xfer(1'b1, `ADDR_FIFO_LAST, 32'h2222_0001);
        while (pops != 8'h02) @(posedge hclk);
        chk("last flag out", 32'h1, {31'h0, last_seen});
        chk("last data out", 32'h2222_0001, last_data);
        tx_stall <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (i < 5) begin
                xfer(1'b1, `ADDR_FIFO_PRIMARY, 32'(i));
            end
            @(posedge hclk);
            res_go <= 1'b1;
            res_in <= 6'h01 << i;
            @(posedge hclk);
            res_go <= 1'b0;
            rd_chk("tx status", `ADDR_TX_STATUS, 32'h0400 << i);
            rd_chk("tx status again", `ADDR_TX_STATUS, 32'h0400 << i);
            xfer(1'b0, GS, 32'h0);
            chk("flags after outcome", 32'h0003_0000, rd & 32'h000F_0000);
            xfer(1'b1, GS, 32'h0002_0000);
            xfer(1'b0, GS, 32'h0);
            chk("flags after clear", 32'h000C_0000, rd & 32'h000E_0000);
        end
        tx_stall <= 1'b0;
        rd_chk("level empty", `ADDR_RX_LEVEL, 32'h0);
        @(posedge hclk);
        rx_go <= 1'b1;
        @(posedge hclk);
        rx_go <= 1'b0;
        rd = 32'h0;
        while (!rd[25]) xfer(1'b0, GS, 32'h0);
        rd_chk("level", `ADDR_RX_LEVEL, 32'h6);
        rd_chk("closed fifo", `ADDR_FIFO_PRIMARY, 32'h0);
        rd_chk("rx status", `ADDR_RX_STATUS, FSTAT);
        xfer(1'b1, GS, 32'h0200_0000);
        rd_chk("word 0", `ADDR_FIFO_PRIMARY, W0);
        rd_chk("word 1", `ADDR_FIFO_PRIMARY, W1);
        rd_chk("level drained", `ADDR_RX_LEVEL, 32'h0);
        xfer(1'b1, `ADDR_CONTROL, 32'h1);
        @(posedge hclk);
        rx_go <= 1'b1;
        @(posedge hclk);
        rx_go <= 1'b0;
        while (dma_cnt == 0) @(posedge hclk);
        xfer(1'b0, GS, 32'h0);
        chk("ready auto clear", 32'h0, {31'h0, rd[25]});
        chk("dma rx status", FSTAT, dma_stat);
        @(posedge hclk);
        res_go <= 1'b1;
        res_in <= 6'h30;
        @(posedge hclk);
        res_go <= 1'b0;
        rd_chk("dma tx status", `ADDR_TX_STATUS, 32'h0000_C000);
        chk("descriptor field", 32'h0000_C000, {16'h0, desc_seen});
        end_of_test();
    end
endmodule : tb_eth_fifo_port
